// ===== inc/lscl_pkg.sv
// Shared constants and types of the LED channel shift/latch controller
package lscl_pkg;
   localparam int          LSCL_CHANNELS   = 8;
   localparam int          LSCL_FIFO_DEPTH = 32;
   localparam int          LSCL_SYNC_DEPTH = 2;
   localparam logic [7:0]  LSCL_SHIFT_RST  = 8'h00;
   localparam logic [7:0]  LSCL_LATCH_RST  = 8'h00;
   localparam logic [7:0]  LSCL_SINKS_OFF  = 8'h00;
   localparam int          LSCL_MSB        = LSCL_CHANNELS - 1;
   typedef logic [LSCL_CHANNELS-1:0] lscl_word_t;
   typedef enum logic [2:0] {
      LSCL_ST_RUN  = 3'b001,
      LSCL_ST_HOT  = 3'b010,
      LSCL_ST_COOL = 3'b100
   } lscl_therm_e;
endpackage

// ===== inc/lscl_stream_if.sv
// Valid/ready word stream between the link side and the core side
`timescale 1ns/1ps
interface lscl_stream_if #(parameter int WIDTH = 8);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ===== verilog/lscl_fifo.sv
// Dual-clock FIFO with gray-coded pointers
`timescale 1ns/1ps
module lscl_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic i_wclk,
   input  wire logic i_wrst,
   input  wire logic i_rclk,
   input  wire logic i_rrst,
   lscl_stream_if.snk wr,
   lscl_stream_if.src rd
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wbin_reg, rbin_reg, wgray_reg, rgray_reg;
   logic [AW:0]      rg_s1_reg, rg_s2_reg, wg_s1_reg, wg_s2_reg;
   logic [AW:0]      wbin_next, rbin_next;
   wire              full_w;
   wire              empty_w;
   wire              push_w;
   wire              pop_w;
   // ======================================================
   // Status
   assign full_w  = wgray_reg == {~rg_s2_reg[AW:AW-1], rg_s2_reg[AW-2:0]};
   assign empty_w = rgray_reg == wg_s2_reg;
   assign push_w  = wr.valid & ~full_w;
   assign pop_w   = rd.ready & ~empty_w;
   assign wbin_next = wbin_reg + (AW+1)'(push_w);
   assign rbin_next = rbin_reg + (AW+1)'(pop_w);
   assign wr.ready = ~full_w;
   assign rd.valid = ~empty_w;
   assign rd.data  = mem[rbin_reg[AW-1:0]];
   // ======================================================
   // Write side
   always_ff @(posedge i_wclk) begin
      if (push_w) begin
         mem[wbin_reg[AW-1:0]] <= wr.data;
      end
   end
   always_ff @(posedge i_wclk or posedge i_wrst) begin
      if (i_wrst) begin
         wbin_reg  <= '0;
         wgray_reg <= '0;
         rg_s1_reg <= '0;
         rg_s2_reg <= '0;
      end else begin
         wbin_reg  <= wbin_next;
         wgray_reg <= wbin_next ^ (wbin_next >> 1);
         rg_s1_reg <= rgray_reg;
         rg_s2_reg <= rg_s1_reg;
      end
   end
   // ======================================================
   // Read side
   always_ff @(posedge i_rclk or posedge i_rrst) begin
      if (i_rrst) begin
         rbin_reg  <= '0;
         rgray_reg <= '0;
         wg_s1_reg <= '0;
         wg_s2_reg <= '0;
      end else begin
         rbin_reg  <= rbin_next;
         rgray_reg <= rbin_next ^ (rbin_next >> 1);
         wg_s1_reg <= wgray_reg;
         wg_s2_reg <= wg_s1_reg;
      end
   end
endmodule

// ===== verilog/lscl_top.sv
// Serial shift register, load latch, output gate and thermal cutoff
`timescale 1ns/1ps
//
// Overview of operation
// - Rising serial clock shifts input into stage zero
// - Strobe high: latch follows shift register
// - Strobe low: latch holds its contents
// - Gate high forces all sinks off
// - Over upper threshold: all channels off
// - Re-enable only below lower threshold
// - Cutoff leaves shift and latch untouched
// - Channels set individually via shift and strobe
// - Eight-bit words, most significant bit first
// - Serial output is last stage, eight delay
// - Latch captures at strobe falling edge
// - Shift and latch independent of gate
module lscl_top
   import lscl_pkg::*;
#(
   parameter int CHANNELS   = LSCL_CHANNELS,
   parameter int FIFO_DEPTH = LSCL_FIFO_DEPTH
) (
   input  wire logic                I_CLOCK,
   input  wire logic                I_RST,
   input  wire logic                I_SERIAL_CLK,
   input  wire logic                I_SERIAL_IN,
   input  wire logic                I_LOAD_STROBE,
   input  wire logic                I_OUTPUT_GATE_N,
   input  wire logic                I_TEMP_ABOVE_UPPER,
   input  wire logic                I_TEMP_BELOW_LOWER,
   output logic                     O_SERIAL_OUT,
   output logic [CHANNELS-1:0]      O_CHANNEL_SINKS,
   output logic                     O_THERMAL_OFF
);
   // ======================================================
   // Link-side reset synchroniser
   logic                lrst_s1_reg;
   logic                lrst_reg;
   logic [CHANNELS-1:0] shift_reg;
   logic [CHANNELS-1:0] shift_next;
   logic                sout_reg;

   always_ff @(posedge I_SERIAL_CLK or posedge I_RST) begin
      if (I_RST) begin
         lrst_s1_reg <= 1'b1;
         lrst_reg    <= 1'b1;
      end else begin
         lrst_s1_reg <= 1'b0;
         lrst_reg    <= lrst_s1_reg;
      end
   end

   // ======================================================
   // Shift register on the serial clock
   // MSB first: first bit ends at top
   assign shift_next = {shift_reg[CHANNELS-2:0], I_SERIAL_IN};

   always_ff @(posedge I_SERIAL_CLK or posedge lrst_reg) begin
      if (lrst_reg) begin
         shift_reg <= LSCL_SHIFT_RST[CHANNELS-1:0];
      end else begin
         shift_reg <= shift_next;
      end
   end

   always_ff @(posedge I_SERIAL_CLK or posedge lrst_reg) begin
      if (lrst_reg) begin
         sout_reg <= 1'b0;
      end else begin
         sout_reg <= shift_next[CHANNELS-1];
      end
   end

   // ======================================================
   // Word stream to the core clock
   lscl_stream_if #(.WIDTH(CHANNELS)) wr_if ();
   lscl_stream_if #(.WIDTH(CHANNELS)) rd_if ();

   assign wr_if.valid = ~lrst_reg;
   assign wr_if.data  = shift_next;

   lscl_fifo #(
      .WIDTH (CHANNELS),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_wclk (I_SERIAL_CLK),
      .i_wrst (I_RST),
      .i_rclk (I_CLOCK),
      .i_rrst (I_RST),
      .wr     (wr_if),
      .rd     (rd_if)
   );

   // ======================================================
   // Core-side state
   logic [CHANNELS-1:0] mirror_reg;
   logic [CHANNELS-1:0] latch_reg;
   logic [CHANNELS-1:0] sinks_reg;
   logic                sout_s1_reg;
   logic                sout_s2_reg;
   logic                le_s1_reg;
   logic                le_reg;
   logic                oe_s1_reg;
   logic                oe_n_reg;
   logic                hot_s1_reg;
   logic                hot_reg;
   logic                cool_s1_reg;
   logic                cool_reg;
   lscl_therm_e         therm_reg;
   lscl_therm_e         therm_next;
   logic                therm_off_reg;
   wire                 pop_w;
   wire [CHANNELS-1:0]  mirror_next;
   wire [CHANNELS-1:0]  latch_next;
   wire                 cut_w;
   wire [CHANNELS-1:0]  sinks_next;

   // Core drains every word at once
   assign rd_if.ready = 1'b1;
   assign pop_w       = rd_if.valid;
   assign mirror_next = pop_w ? rd_if.data : mirror_reg;

   // Last value kept at strobe fall
   assign latch_next = le_reg ? mirror_next : latch_reg;

   // ======================================================
   // Pin synchronisers
   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         le_s1_reg   <= 1'b0;
         le_reg      <= 1'b0;
         oe_s1_reg   <= 1'b1;
         oe_n_reg    <= 1'b1;
         hot_s1_reg  <= 1'b0;
         hot_reg     <= 1'b0;
         cool_s1_reg <= 1'b0;
         cool_reg    <= 1'b0;
         sout_s1_reg <= 1'b0;
         sout_s2_reg <= 1'b0;
      end else begin
         le_s1_reg   <= I_LOAD_STROBE;
         le_reg      <= le_s1_reg;
         oe_s1_reg   <= I_OUTPUT_GATE_N;
         oe_n_reg    <= oe_s1_reg;
         hot_s1_reg  <= I_TEMP_ABOVE_UPPER;
         hot_reg     <= hot_s1_reg;
         cool_s1_reg <= I_TEMP_BELOW_LOWER;
         cool_reg    <= cool_s1_reg;
         sout_s1_reg <= sout_reg;
         sout_s2_reg <= sout_s1_reg;
      end
   end

   // ======================================================
   // Thermal cutoff
   always_comb begin
      therm_next = therm_reg;
      case (therm_reg)
         LSCL_ST_RUN: begin
            if (hot_reg) begin
               therm_next = LSCL_ST_HOT;
            end
         end
         LSCL_ST_HOT: begin
            if (cool_reg && !hot_reg) begin
               therm_next = LSCL_ST_COOL;
            end
         end
         LSCL_ST_COOL: begin
            therm_next = hot_reg ? LSCL_ST_HOT : LSCL_ST_RUN;
         end
         default: begin
            therm_next = LSCL_ST_HOT;
         end
      endcase
   end

   assign cut_w = (therm_next != LSCL_ST_RUN);

   assign sinks_next = (oe_n_reg || cut_w) ?
                       LSCL_SINKS_OFF[CHANNELS-1:0] : latch_next;

   // ======================================================
   // Core registers
   // Cutoff only masks the sinks
   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         mirror_reg <= LSCL_SHIFT_RST[CHANNELS-1:0];
         latch_reg  <= LSCL_LATCH_RST[CHANNELS-1:0];
         sinks_reg  <= LSCL_SINKS_OFF[CHANNELS-1:0];
         therm_reg  <= LSCL_ST_RUN;
         therm_off_reg <= 1'b0;
      end else begin
         mirror_reg <= mirror_next;
         latch_reg  <= latch_next;
         sinks_reg  <= sinks_next;
         therm_reg  <= therm_next;
         therm_off_reg <= cut_w;
      end
   end

   assign O_CHANNEL_SINKS = sinks_reg;
   assign O_THERMAL_OFF   = therm_off_reg;
   assign O_SERIAL_OUT    = sout_s2_reg;
endmodule

// ===== sim/lscl_top_asserts.sv
// Port checker of the LED channel controller
`timescale 1ns/1ps
module lscl_top_asserts
   import lscl_pkg::*;
#(parameter int CHANNELS = LSCL_CHANNELS)
(
   input wire logic                I_CLOCK,
   input wire logic                I_RST,
   input wire logic                I_SERIAL_CLK,
   input wire logic                I_LOAD_STROBE,
   input wire logic                I_OUTPUT_GATE_N,
   input wire logic                I_TEMP_ABOVE_UPPER,
   input wire logic                I_TEMP_BELOW_LOWER,
   input wire logic                O_SERIAL_OUT,
   input wire logic [CHANNELS-1:0] O_CHANNEL_SINKS,
   input wire logic                O_THERMAL_OFF
);
   logic [5:0] hot_hist_reg;
   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) hot_hist_reg <= 6'h00;
      else hot_hist_reg <= {hot_hist_reg[4:0], I_TEMP_ABOVE_UPPER};
   end
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (I_RST);
   sequence s_quiet;
      !I_LOAD_STROBE && !I_OUTPUT_GATE_N && !O_THERMAL_OFF &&
      !I_TEMP_ABOVE_UPPER;
   endsequence
   sequence s_hot_wait;
      (!I_TEMP_BELOW_LOWER) [*4] ##0 O_THERMAL_OFF;
   endsequence
   a_gate_forces_off: assert property (I_OUTPUT_GATE_N [*4] |->
      O_CHANNEL_SINKS == LSCL_SINKS_OFF) else $error("Sinks on, gate high");
   a_hot_trips: assert property ($rose(I_TEMP_ABOVE_UPPER) |->
      ##[1:6] O_THERMAL_OFF) else $error("No cutoff when hot");
   a_cutoff_sinks_off: assert property (O_THERMAL_OFF [*2] |->
      O_CHANNEL_SINKS == LSCL_SINKS_OFF) else $error("Sinks on in cutoff");
   a_trip_cause: assert property ($rose(O_THERMAL_OFF) |->
      |hot_hist_reg) else $error("Cutoff without heat");
   a_cutoff_hold: assert property (s_hot_wait ##1 !I_TEMP_BELOW_LOWER |->
      O_THERMAL_OFF) else $error("Cutoff released early");
   a_release_cool: assert property ($fell(O_THERMAL_OFF) |->
      !$past(I_TEMP_ABOVE_UPPER, 3)) else $error("Released while hot");
   a_latch_holds: assert property (s_quiet [*8] |=>
      $stable(O_CHANNEL_SINKS)) else $error("Sinks moved, strobe low");
   a_shift_idle: assert property ($stable(I_SERIAL_CLK) [*8] |=>
      $stable(O_SERIAL_OUT)) else $error("Serial out moved, no clock");
endmodule
bind lscl_top lscl_top_asserts #(.CHANNELS(CHANNELS)) u_chk (.I_CLOCK,
   .I_RST, .I_SERIAL_CLK, .I_LOAD_STROBE, .I_OUTPUT_GATE_N,
   .I_TEMP_ABOVE_UPPER, .I_TEMP_BELOW_LOWER, .O_SERIAL_OUT,
   .O_CHANNEL_SINKS, .O_THERMAL_OFF);

// ===== sim/lscl_uc_model.sv
// Serial controller model driving the shift and strobe pins
`timescale 1ns/1ps
module lscl_uc_model (
   output logic o_sclk,
   output logic o_sin,
   output logic o_strobe
);
   initial begin
      o_sclk = 1'b0;
      o_sin = 1'b0;
      o_strobe = 1'b0;
   end
   task automatic clock_bit(input logic b, input int gap);
      o_sin = b;
      #(15 + gap);
      o_sclk = 1'b1;
      #15;
      o_sclk = 1'b0;
   endtask
   task automatic shift_word(input logic [7:0] w, input int gap);
      for (int i = 7; i >= 0; i--) clock_bit(w[i], gap);
   endtask
   task automatic strobe();
      #60 o_strobe = 1'b1;
      #40 o_strobe = 1'b0;
   endtask
   task automatic standalone();
      o_strobe = 1'b1;
      repeat (8) clock_bit(1'b1, 0);
      #60 o_strobe = 1'b0;
   endtask
endmodule

// ===== sim/lscl_top_test.sv
// Self-checking bench of the LED channel controller
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
   $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module lscl_top_test
   import lscl_pkg::*;
;
   logic       clk, rst, gate_n, hot, cool, sclk, sin, strobe, sout, therm;
   lscl_word_t sinks;
   logic [8:0] notes[$];
   logic [8:0] note;
   int         err_count = 0, n_checks = 0, cycles = 0, seed = 28197;
   event       chk;
   always #2 clk = ~clk;
   lscl_uc_model uc (.o_sclk(sclk), .o_sin(sin), .o_strobe(strobe));
   lscl_top dut (
      .I_CLOCK(clk), .I_RST(rst), .I_SERIAL_CLK(sclk), .I_SERIAL_IN(sin),
      .I_LOAD_STROBE(strobe), .I_OUTPUT_GATE_N(gate_n),
      .I_TEMP_ABOVE_UPPER(hot), .I_TEMP_BELOW_LOWER(cool),
      .O_SERIAL_OUT(sout), .O_CHANNEL_SINKS(sinks), .O_THERMAL_OFF(therm));
   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic expect_out(input logic t, input lscl_word_t v);
      notes.push_back({t, v});
      repeat (16) @(negedge clk);
      -> chk;
   endtask
   always @(chk) begin
      note = notes.pop_front();
      `CHK({therm, sinks}, note)
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         wrap_up();
      end
   end
   initial begin
      lscl_word_t w, last;
      clk = 1'b0;
      rst = 1'b1;
      gate_n = 1'b0;
      hot = 1'b0;
      cool = 1'b0;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      #7 uc.clock_bit(1'b0, 0);
      uc.clock_bit(1'b0, 0);
      for (int i = 0; i < 6; i++) begin
         w = (i < 2) ? (i ? 8'h01 : 8'h80) : 8'($random(seed));
         uc.shift_word(w, 0);
         uc.strobe();
         expect_out(1'b0, w);
      end
      $display("Words done");
      last = w;
      w = 8'($random(seed));
      uc.shift_word(w, 0);
      repeat (12) @(negedge clk);
      `CHK(sout, w[7])
      expect_out(1'b0, last);
      $display("Hold done");
      @(negedge clk) gate_n = 1'b1;
      expect_out(1'b0, LSCL_SINKS_OFF);
      uc.strobe();
      @(negedge clk) gate_n = 1'b0;
      expect_out(1'b0, w);
      repeat (3) begin
         @(negedge clk) gate_n = 1'b1;
         expect_out(1'b0, LSCL_SINKS_OFF);
         @(negedge clk) gate_n = 1'b0;
         expect_out(1'b0, w);
      end
      $display("Gate done");
      @(negedge clk) hot = 1'b1;
      expect_out(1'b1, LSCL_SINKS_OFF);
      @(negedge clk) hot = 1'b0;
      expect_out(1'b1, LSCL_SINKS_OFF);
      @(negedge clk) cool = 1'b1;
      expect_out(1'b0, w);
      `CHK(sout, w[7])
      @(negedge clk) cool = 1'b0;
      $display("Thermal done");
      uc.standalone();
      expect_out(1'b0, 8'hff);
      $display("Stand-alone done");
      wrap_up();
   end
endmodule
